// ---- bdp_pkg.sv ----
// Constants and types shared by the bidirectional port files
package bdp_pkg;

  // ==========================================================
  // Register byte offsets on the APB
  localparam logic [7:0] BDP_OFF_DATA = 8'h00;   // port_data_latch
  localparam logic [7:0] BDP_OFF_DIR = 8'h04;    // port_direction_select
  localparam logic [7:0] BDP_OFF_BITOP = 8'h08;  // Bit set / clear command
  localparam logic [7:0] BDP_OFF_STAT = 8'h0c;   // Engine status

  // ==========================================================
  // Reset values and fixed read values
  localparam logic [7:0] BDP_DATA_RST = 8'h00;
  localparam logic [7:0] BDP_DIR_RST = 8'h00;    // All pins start as inputs
  localparam logic [7:0] BDP_BITOP_RST = 8'h00;
  localparam logic [7:0] BDP_DIR_READ_VAL = 8'hff;

  // ==========================================================
  // Field positions
  localparam int BDP_BITOP_IDX_LSB = 0;          // Bits 2:0 select the bit
  localparam int BDP_BITOP_SET_POS = 3;          // 1 sets, 0 clears
  localparam int BDP_BITOP_TGT_POS = 4;          // 0 data latch, 1 direction
  localparam int BDP_STAT_BUSY_POS = 0;
  localparam int BDP_STAT_RD_LSB = 8;            // Byte read by last operation
  localparam int BDP_PINS = 8;

  // ==========================================================
  // Read-modify-write engine states
  typedef enum logic [2:0] {
    BDP_IDLE,
    BDP_READ,
    BDP_MOD,
    BDP_WRITE,
    BDP_DONE
  } bdp_rmw_e;

endpackage

// ---- bdp_pin_cell.sv ----
// One pin of the port: latch bit, direction bit and pin drivers
module bdp_pin_cell
  import bdp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic lat_we,
  input wire logic lat_d,
  input wire logic dir_we,
  input wire logic dir_d,
  output logic lat_q,
  output logic dir_q,
  output logic pin_o,
  output logic pin_oe_n
);

  // ==========================================================
  // Latch bit, written whatever the direction
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lat_q <= BDP_DATA_RST[0];
    end else if (lat_we) begin
      lat_q <= lat_d;
    end
  end

  // Pin level follows the latch; it only reaches the wire when enabled
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_o <= BDP_DATA_RST[0];
    end else if (lat_we) begin
      pin_o <= lat_d;
    end
  end

  // ==========================================================
  // Direction bit and the driver enable, low while driving
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dir_q <= BDP_DIR_RST[0];
      pin_oe_n <= ~BDP_DIR_RST[0];
    end else if (dir_we) begin
      dir_q <= dir_d;
      pin_oe_n <= ~dir_d;
    end
  end

endmodule

// ---- bdp_port.sv ----
// Eight-pin bidirectional port with APB registers and bit set / clear engine
//
// Functional notes
// - Data read returns live pin level for every input-configured bit.
// - Data read returns the latch value for every output-configured bit.
// - Bit set/clear is done as byte read, single-bit change, full byte write.
// - Byte write to data register updates all eight latch bits, inputs included.
// - Output pin is driven high for latch 1 and low for latch 0.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Read samples pins and latch now; write-back stores sampled input levels.
// - Direction register is write-only; reads return all ones.
module bdp_port
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [bdp_pkg::BDP_PINS-1:0] port_pin_i,
  output logic [bdp_pkg::BDP_PINS-1:0] port_pin_o,
  output logic [bdp_pkg::BDP_PINS-1:0] port_pin_oe_n
);
  import bdp_pkg::*;

  logic [7:0] lat_q;
  logic [7:0] dir_q;
  logic [7:0] lat_we;
  logic [7:0] dir_we;
  logic [7:0] lat_d;
  logic [7:0] dir_d;
  logic [7:0] data_view;
  logic [7:0] bitop_r;
  logic [7:0] rd_r;
  logic [7:0] mod_r;
  logic [7:0] bit_mask;
  bdp_rmw_e state_r;
  bdp_rmw_e state_nxt;
  logic access;
  logic commit;
  logic hit_data;
  logic hit_dir;
  logic hit_bitop;
  logic hit_stat;
  logic bitop_wr;
  logic eng_wr_data;
  logic eng_wr_dir;

  // ==========================================================
  // Bus decode
  assign access = psel && penable;
  assign commit = access && pready;
  assign hit_data = (paddr == BDP_OFF_DATA);
  assign hit_dir = (paddr == BDP_OFF_DIR);
  assign hit_bitop = (paddr == BDP_OFF_BITOP);
  assign hit_stat = (paddr == BDP_OFF_STAT);
  assign bitop_wr = pwrite && hit_bitop;

  // Byte the port shows to a reader: pins for inputs, latch for outputs
  assign data_view = (port_pin_i & ~dir_q) | (lat_q & dir_q);

  // ==========================================================
  // Per-pin latch and direction cells
  assign eng_wr_data = (state_r == BDP_WRITE) && !bitop_r[BDP_BITOP_TGT_POS];
  assign eng_wr_dir = (state_r == BDP_WRITE) && bitop_r[BDP_BITOP_TGT_POS];
  assign lat_we = {8{(commit && pwrite && hit_data) || eng_wr_data}};
  assign dir_we = {8{(commit && pwrite && hit_dir) || eng_wr_dir}};
  assign lat_d = eng_wr_data ? mod_r : pwdata[7:0];
  assign dir_d = eng_wr_dir ? mod_r : pwdata[7:0];

  genvar gi;
  generate
    for (gi = 0; gi < BDP_PINS; gi++) begin : g_pin
      bdp_pin_cell u_cell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .lat_we(lat_we[gi]),
        .lat_d(lat_d[gi]),
        .dir_we(dir_we[gi]),
        .dir_d(dir_d[gi]),
        .lat_q(lat_q[gi]),
        .dir_q(dir_q[gi]),
        .pin_o(port_pin_o[gi]),
        .pin_oe_n(port_pin_oe_n[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Read-modify-write engine sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BDP_IDLE: begin
        if (access && !pready && bitop_wr) begin
          state_nxt = BDP_READ;
        end
      end
      BDP_READ: begin
        state_nxt = BDP_MOD;
      end
      BDP_MOD: begin
        state_nxt = BDP_WRITE;
      end
      BDP_WRITE: begin
        state_nxt = BDP_DONE;
      end
      BDP_DONE: begin
        state_nxt = BDP_IDLE;
      end
      default: begin
        state_nxt = BDP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= BDP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Command is caught as the engine starts
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bitop_r <= BDP_BITOP_RST;
    end else if (state_r == BDP_IDLE && access && !pready && bitop_wr) begin
      bitop_r <= pwdata[7:0];
    end
  end

  // Read step: whole byte, direction reads as all ones like any reader
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_r <= BDP_DATA_RST;
    end else if (state_r == BDP_READ) begin
      rd_r <= bitop_r[BDP_BITOP_TGT_POS] ? BDP_DIR_READ_VAL : data_view;
    end
  end

  // Modify step: only the addressed bit changes
  assign bit_mask = 8'h01 << bitop_r[BDP_BITOP_IDX_LSB +: 3];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mod_r <= BDP_DATA_RST;
    end else if (state_r == BDP_MOD) begin
      if (bitop_r[BDP_BITOP_SET_POS]) begin
        mod_r <= rd_r | bit_mask;
      end else begin
        mod_r <= rd_r & ~bit_mask;
      end
    end
  end

  // ==========================================================
  // APB answer: one wait state, longer while the engine runs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready && (!bitop_wr || state_r == BDP_DONE);
    end
  end

  // Read data and error, loaded as pready rises
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pslverr <= !(hit_data || hit_dir || hit_bitop || hit_stat);
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        if (hit_data) begin
          prdata <= {24'h00_0000, data_view};
        end else if (hit_dir) begin
          prdata <= {24'h00_0000, BDP_DIR_READ_VAL};
        end else if (hit_bitop) begin
          prdata <= {24'h00_0000, bitop_r};
        end else if (hit_stat) begin
          prdata[BDP_STAT_BUSY_POS] <= (state_r != BDP_IDLE);
          prdata[BDP_STAT_RD_LSB +: 8] <= rd_r;
        end
      end
    end else begin
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic rd_done;
  assign rd_done = access && !pready && !pwrite;

  sequence s_rmw_read;
    state_r == BDP_READ;
  endsequence

  sequence s_rmw_tail;
    state_r == BDP_MOD ##1 state_r == BDP_WRITE ##1 state_r == BDP_DONE;
  endsequence

  property p_rd_inputs;
    rd_done && hit_data |=> (prdata[7:0] & ~$past(dir_q)) == ($past(port_pin_i) & ~$past(dir_q));
  endproperty
  a_rd_inputs: assert property (p_rd_inputs) else $error("Input bit read not pin level");

  property p_rd_outputs;
    rd_done && hit_data |=> (prdata[7:0] & $past(dir_q)) == ($past(lat_q) & $past(dir_q));
  endproperty
  a_rd_outputs: assert property (p_rd_outputs) else $error("Output bit read not latch");

  property p_rmw_steps;
    s_rmw_read |=> s_rmw_tail;
  endproperty
  a_rmw_steps: assert property (p_rmw_steps) else $error("Bit operation steps out of order");

  property p_rmw_onebit;
    state_r == BDP_WRITE |-> ((mod_r ^ rd_r) & ~bit_mask) == 8'h00;
  endproperty
  a_rmw_onebit: assert property (p_rmw_onebit) else $error("Other bits changed by bit op");

  property p_byte_write;
    commit && pwrite && hit_data |=> lat_q == $past(pwdata[7:0]) ##1 lat_q == $past(lat_q);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("Latch not loaded by byte write");

  property p_drive_level;
    commit && pwrite && hit_data |=>
      (port_pin_o & ~port_pin_oe_n) == ($past(pwdata[7:0]) & ~port_pin_oe_n);
  endproperty
  a_drive_level: assert property (p_drive_level) else $error("Driven level not latch");

  property p_dir_write;
    commit && pwrite && hit_dir |=> port_pin_oe_n == ~$past(pwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("Direction write not applied");

  property p_sample_store;
    s_rmw_read ##0 !bitop_r[BDP_BITOP_TGT_POS] |=> rd_r == $past(data_view) ##2
      (lat_q & ~bit_mask) == ($past(rd_r, 2) & ~bit_mask);
  endproperty
  a_sample_store: assert property (p_sample_store) else $error("Sampled byte not written back");

  property p_dir_reads_ones;
    rd_done && hit_dir |=> prdata == 32'h0000_00ff;
  endproperty
  a_dir_reads_ones: assert property (p_dir_reads_ones) else $error("Direction read not all ones");

  property p_input_off;
    eng_wr_dir |=> port_pin_oe_n == ~$past(mod_r);
  endproperty
  a_input_off: assert property (p_input_off) else $error("Input pin driver enabled");

  // ==========================================================
  // Bit operation start and read step, then bit operation and byte write side effects: only the target register moves
  property p_bitop_start;
    access && !pready && bitop_wr && state_r == BDP_IDLE |=> s_rmw_read;
  endproperty
  a_bitop_start: assert property (p_bitop_start) else $error("Engine did not start");

  property p_rmw_dir_read;
    s_rmw_read ##0 bitop_r[BDP_BITOP_TGT_POS] |=> rd_r == BDP_DIR_READ_VAL;
  endproperty
  a_rmw_dir_read: assert property (p_rmw_dir_read) else $error("Dir op read not ones");

  property p_rmw_keep_dir;
    eng_wr_data |=> $stable(dir_q);
  endproperty
  a_rmw_keep_dir: assert property (p_rmw_keep_dir) else $error("Direction disturbed");

  property p_rmw_keep_lat;
    eng_wr_dir |=> $stable(lat_q);
  endproperty
  a_rmw_keep_lat: assert property (p_rmw_keep_lat) else $error("Latch disturbed");

  property p_keep_drv;
    commit && pwrite && hit_data |=> $stable(port_pin_oe_n);
  endproperty
  a_keep_drv: assert property (p_keep_drv) else $error("Data write moved driver");

  // ==========================================================
  // Bus answer: one-cycle reply, refusal of unmapped words, status
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");

  property p_bad_addr;
    access && !pready && !(hit_data || hit_dir || hit_bitop || hit_stat) |=>
      pready && pslverr;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("Unmapped access not refused");

  property p_stat_read;
    rd_done && hit_stat |=> prdata[BDP_STAT_RD_LSB +: 8] == $past(rd_r);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("Status byte wrong");

endmodule

// ---- bdp_pin_model.sv ----
// External side of the port pins: an outside source and the wire level
module bdp_pin_model
  import bdp_pkg::*;
(
  input wire logic [bdp_pkg::BDP_PINS-1:0] ext_level,
  input wire logic [bdp_pkg::BDP_PINS-1:0] port_pin_o,
  input wire logic [bdp_pkg::BDP_PINS-1:0] port_pin_oe_n,
  output logic [bdp_pkg::BDP_PINS-1:0] port_pin_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Device drives enabled pins, the outside source holds the rest
  assign port_pin_i = (ext_level & port_pin_oe_n) | (port_pin_o & ~port_pin_oe_n);
endmodule

// ---- bidir_port_with_direction_bench.sv ----
// Self-checking bench for the bidirectional port
module bidir_port_with_direction_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import bdp_pkg::*;
  typedef struct {logic [31:0] rd; logic err; bit is_rd;} bdp_exp_s;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, pin_i, pin_o, pin_oe_n, ext, lat, dir;
  logic [31:0] pwdata, prdata;
  logic [15:0] rnd;
  bdp_exp_s q[$];
  int errors = 0;
  int n_tests = 0;

  // ==========================================================
  // Design and pin partner
  bdp_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pin_i(pin_i), .port_pin_o(pin_o), .port_pin_oe_n(pin_oe_n));
  bdp_pin_model u_pins (.ext_level(ext), .port_pin_o(pin_o), .port_pin_oe_n(pin_oe_n),
    .port_pin_i(pin_i));

  // Clock generation
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // APB transfer; expectation queued for the watcher
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] rd, input logic err);
    q.push_back('{rd, err, !w});
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // Wait for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask

  function automatic logic [7:0] view();
    return (ext & ~dir) | (lat & dir);
  endfunction

  task automatic rd_dat;
    apb(0, BDP_OFF_DATA, 0, {24'h0, view()}, 0);
  endtask

  // Bit operation, then its status and command readback
  task automatic bitop(input logic [2:0] i, input logic s, input logic t);
    logic [7:0] v, nv;
    v = t ? 8'hff : view();
    nv = v;
    nv[i] = s;
    if (t) dir = nv;
    else lat = nv;
    apb(1, BDP_OFF_BITOP, {27'h0, t, s, i}, 0, 0);
    apb(0, BDP_OFF_STAT, 0, {16'h0, v, 8'h00}, 0);
    apb(0, BDP_OFF_BITOP, 0, {27'h0, t, s, i}, 0);
  endtask

  task automatic pins;
    repeat (2) @(posedge clk_sys);
    chk("pin_o", {24'h0, lat}, {24'h0, pin_o});
    chk("pin_oe_n", {24'h0, ~dir}, {24'h0, pin_oe_n});
  endtask

  // ==========================================================
  // Watcher: completed transfers against the oldest note
  always @(posedge clk_sys) begin
    bdp_exp_s e;
    if (pready === 1'b1) begin
      if (q.size() == 0) chk("extra", 0, 1);
      else begin
        e = q.pop_front();
        chk("pslverr", {31'h0, e.err}, {31'h0, pslverr});
        if (e.is_rd) chk("prdata", e.rd, prdata);
      end
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    ext = 8'h40;
    lat = 0;
    dir = 0;
    rnd = 16'd48191;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
    pins();
    apb(1, BDP_OFF_DIR, 32'hffff_ff3f, 0, 0);
    dir = 8'h3f;
    apb(1, BDP_OFF_DATA, 32'h0000_0080, 0, 0);
    lat = 8'h80;
    pins();
    rd_dat();
    apb(0, BDP_OFF_DIR, 0, 32'hff, 0);
    bitop(0, 1, 0);
    pins();
    bitop(0, 0, 1);
    ext <= 8'h41;
    pins();
    rd_dat();
    apb(1, 8'h10, 32'h55, 0, 1);
    apb(0, 8'h10, 0, 0, 1);
    rd_dat();
    repeat (24) begin
      rnd = lfsr(rnd);
      ext <= rnd[7:0];
      // Fresh value for direction so input pins can also read ones
      rnd = lfsr(rnd);
      apb(1, BDP_OFF_DIR, {16'h0, rnd}, 0, 0);
      dir = rnd[7:0];
      rnd = lfsr(rnd);
      apb(1, BDP_OFF_DATA, {16'h0, rnd}, 0, 0);
      lat = rnd[7:0];
      pins();
      rd_dat();
      rnd = lfsr(rnd);
      bitop(rnd[2:0], rnd[3], rnd[4]);
      pins();
      rd_dat();
    end
    // Reset again in mid-run: latch and direction go back to zero
    rst_n <= 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    lat = 0;
    dir = 0;
    pins();
    rd_dat();
    final_report();
  end
endmodule
